// file: inc/vds_cfg.svh
`ifndef VDS_CFG_SVH
`define VDS_CFG_SVH

`define VDS_CLK_NS 40
`define VDS_SAMPLE_NS 180
`define VDS_STEP_NS 540
`define VDS_SAMPLE_CYC ((`VDS_SAMPLE_NS + `VDS_CLK_NS - 1) / `VDS_CLK_NS)
`define VDS_STEP_CYC ((`VDS_STEP_NS + `VDS_CLK_NS - 1) / `VDS_CLK_NS)
`define VDS_QUAL_READS 3'h3
`define VDS_OFF_READS 3'h4
`define VDS_RUN_FIRST 3'h1
`define VDS_RUN_RESET 3'h0
`define VDS_OFF_CODE_LO 8'hFE
`define VDS_OFF_CODE_HI 8'hFF
`define VDS_BOOT_CODE 8'h00
`define VDS_ANCHOR_CODE 8'hA9
`define VDS_ANCHOR_UV 556250
`define VDS_STEP_UV 6250
`define VDS_CODE_ONE 8'h01

`endif

// file: inc/vds_pkg.sv
package vds_pkg;

    typedef enum logic [1:0] {
        VDS_DISABLED = 2'h0,
        VDS_TRACK = 2'h1,
        VDS_LATCHED = 2'h3
    } vds_mode_t;

    typedef struct packed {
        logic regulating;
        logic stepping;
        logic off_latched;
    } vds_status_t;

endpackage

// file: verilog/vds_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none

module vds_tick_gen #(
    parameter int PERIOD = 5
) (
    input wire logic core_clk,
    input wire logic rst,
    output logic tick
);
    localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_q;
    wire at_last = (cnt_q == LAST);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt_q <= at_last ? '0 : cnt_q + CW'(1);
            tick <= at_last;
        end
    end
endmodule

`default_nettype wire

// file: verilog/vds_stepper.sv
// Behaviour
// - Compare input code each sampling tick.
// - New target after three identical readings.
// - Move reference one code per step.
// - One step per period until equal.
// - Transition time proportional to code difference.
// - Code A9 means 0.55625 V, increment lowers.
// - Off codes need four identical readings.
// - Off latches; enable toggle clears it.
`timescale 1ns/1ns
`default_nettype none
`include "vds_cfg.svh"

module vds_stepper #(
    parameter int SAMPLE_CYC = `VDS_SAMPLE_CYC,
    parameter int STEP_CYC = `VDS_STEP_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [7:0] voltage_select_code,
    output logic [7:0] reference_level_q,
    output logic [20:0] reference_uv_q,
    output vds_pkg::vds_status_t status_q
);
    function automatic logic vds_is_off(input logic [7:0] code);
        return (code == `VDS_OFF_CODE_LO) || (code == `VDS_OFF_CODE_HI);
    endfunction

    function automatic logic [20:0] vds_code_to_uv(input logic [7:0] code);
        int v;
        v = `VDS_ANCHOR_UV + (int'(`VDS_ANCHOR_CODE) - int'(code)) * `VDS_STEP_UV;
        return v[20:0];
    endfunction

    logic sample_tick;
    logic step_tick;

    vds_tick_gen #(.PERIOD(SAMPLE_CYC)) u_sample_tick (
        .core_clk(core_clk),
        .rst(rst),
        .tick(sample_tick)
    );

    vds_tick_gen #(.PERIOD(STEP_CYC)) u_step_tick (
        .core_clk(core_clk),
        .rst(rst),
        .tick(step_tick)
    );

    vds_pkg::vds_mode_t mode_q;
    vds_pkg::vds_mode_t mode_d;
    logic [7:0] last_q;
    logic [2:0] run_q;
    logic [7:0] target_q;

    // Readings are counted, not the target compare, so a code bouncing back is requalified
    wire same_read = (voltage_select_code == last_q);
    wire [2:0] run_inc = (run_q == `VDS_OFF_READS) ? run_q : run_q + `VDS_RUN_FIRST;
    wire [2:0] run_d = same_read ? run_inc : `VDS_RUN_FIRST;
    wire read_off = vds_is_off(voltage_select_code);
    wire accept_new = sample_tick && !read_off && (run_d >= `VDS_QUAL_READS)
                      && (voltage_select_code != target_q);
    wire off_seen = sample_tick && read_off && (run_d >= `VDS_OFF_READS);
    wire regulating = (mode_q == vds_pkg::VDS_TRACK);
    wire need_step = (reference_level_q != target_q);
    wire go_down = (target_q < reference_level_q);
    wire do_step = regulating && step_tick && need_step;
    wire [7:0] level_d = go_down ? reference_level_q - `VDS_CODE_ONE
                                 : reference_level_q + `VDS_CODE_ONE;

    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            vds_pkg::VDS_DISABLED:
                if (enable)
                    mode_d = vds_pkg::VDS_TRACK;
            vds_pkg::VDS_TRACK:
                if (!enable)
                    mode_d = vds_pkg::VDS_DISABLED;
                else if (off_seen)
                    mode_d = vds_pkg::VDS_LATCHED;
            vds_pkg::VDS_LATCHED:
                if (!enable)
                    mode_d = vds_pkg::VDS_DISABLED;
            default:
                mode_d = vds_pkg::VDS_DISABLED;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            last_q <= `VDS_BOOT_CODE;
            run_q <= `VDS_RUN_RESET;
        end
        else if (sample_tick)
        begin
            last_q <= voltage_select_code;
            run_q <= run_d;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mode_q <= vds_pkg::VDS_DISABLED;
            target_q <= `VDS_BOOT_CODE;
        end
        else
        begin
            mode_q <= mode_d;
            if (accept_new)
                target_q <= voltage_select_code;
        end
    end

    // Time to settle is at most |delta code| step periods, the first step waits for the free-running tick
    always_ff @(posedge core_clk)
    begin
        if (rst)
            reference_level_q <= `VDS_BOOT_CODE;
        else if (do_step)
            reference_level_q <= level_d;
    end

    // Voltage view lags the code by one cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            reference_uv_q <= vds_code_to_uv(`VDS_BOOT_CODE);
            status_q <= '0;
        end
        else
        begin
            reference_uv_q <= vds_code_to_uv(reference_level_q);
            status_q.regulating <= (mode_d == vds_pkg::VDS_TRACK);
            status_q.stepping <= regulating && need_step;
            status_q.off_latched <= (mode_d == vds_pkg::VDS_LATCHED);
        end
    end

    sequence s_sample_gap;
        !sample_tick [*4];
    endsequence

    property p_sample_rate;
        @(posedge core_clk) disable iff (rst)
        sample_tick |=> s_sample_gap ##1 sample_tick;
    endproperty
    a_sample_rate: assert property (p_sample_rate) else $error("sampling tick period wrong");

    property p_qualify;
        @(posedge core_clk) disable iff (rst)
        !$past(rst) && $changed(target_q) |-> $past(sample_tick) && ($past(run_q) >= 3'h2)
            && ($past(voltage_select_code) == $past(last_q)) && (target_q == $past(voltage_select_code));
    endproperty
    a_qualify: assert property (p_qualify) else $error("target taken without three readings");

    property p_one_code;
        @(posedge core_clk) disable iff (rst)
        do_step |=> ($past(go_down) ? $past(reference_level_q) - reference_level_q
                             : reference_level_q - $past(reference_level_q)) == 8'h01;
    endproperty
    a_one_code: assert property (p_one_code) else $error("step not one code toward target");

    property p_step_only_on_tick;
        @(posedge core_clk) disable iff (rst)
        !$past(rst) && $changed(reference_level_q) |-> $past(step_tick) && $past(regulating);
    endproperty
    a_step_only_on_tick: assert property (p_step_only_on_tick) else $error("reference moved off step tick");

    property p_step_gap;
        @(posedge core_clk) disable iff (rst)
        step_tick |=> !step_tick [*8];
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("step period too short");

    property p_step_due;
        @(posedge core_clk) disable iff (rst)
        regulating && need_step && step_tick && enable && !off_seen |=> $changed(reference_level_q);
    endproperty
    a_step_due: assert property (p_step_due) else $error("step missed");

    property p_anchor;
        @(posedge core_clk) disable iff (rst)
        reference_level_q == 8'hA9 |=> reference_uv_q == 21'h087CDA;
    endproperty
    a_anchor: assert property (p_anchor) else $error("anchor voltage wrong");

    // Code going up must lower the voltage view by one step, two cycles on
    property p_uv_step;
        @(posedge core_clk) disable iff (rst)
        do_step && !go_down |=> ##1 (reference_uv_q == $past(reference_uv_q) - 21'h00186A);
    endproperty
    a_uv_step: assert property (p_uv_step) else $error("voltage step wrong for rising code");

    property p_off_latch;
        @(posedge core_clk) disable iff (rst)
        $rose(status_q.off_latched) |-> $past(sample_tick) && $past(read_off) && ($past(run_q) >= 3'h3);
    endproperty
    a_off_latch: assert property (p_off_latch) else $error("off latched early");

    property p_off_hold;
        @(posedge core_clk) disable iff (rst)
        status_q.off_latched && enable |=> status_q.off_latched && !status_q.regulating;
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("off latch released without enable toggle");

    // Latched off freezes the reference even if a new target qualifies
    property p_latch_freeze;
        @(posedge core_clk) disable iff (rst)
        status_q.off_latched |=> $stable(reference_level_q);
    endproperty
    a_latch_freeze: assert property (p_latch_freeze) else $error("reference moved while latched off");

    property p_restart;
        @(posedge core_clk) disable iff (rst)
        sample_tick && !same_read |=> run_q == 3'h1;
    endproperty
    a_restart: assert property (p_restart) else $error("stability count not restarted");
endmodule

`default_nettype wire

// file: verification/vds_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none

module vds_cpu_model (
    input wire logic core_clk,
    input wire logic [7:0] want_code,
    input wire logic bounce,
    input wire logic want_en,
    output logic [7:0] voltage_select_code,
    output logic enable
);
    logic [1:0] ph_q;
    logic flip_q;

    initial
    begin
        ph_q = 2'h0;
        flip_q = 1'b0;
        voltage_select_code = 8'h00;
        enable = 1'b0;
    end

    // Lsb flips every 4 cycles, so no three reads in a row agree
    always @(posedge core_clk)
    begin
        ph_q <= ph_q + 2'h1;
        if (ph_q == 2'h3)
            flip_q <= ~flip_q;
        voltage_select_code <= #2 want_code ^ {7'h00, bounce & flip_q};
        enable <= #2 want_en;
    end
endmodule

`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic core_clk, rst, want_en, bounce, enable;
    logic [7:0] want_code, code, level, lvl_prev;
    logic [20:0] uv;
    vds_pkg::vds_status_t st;
    int miscompares = 0;
    int checked = 0;
    int scnt = 0;
    bit svalid = 0;
    logic [31:0] seed = 32'd78809;

    vds_cpu_model u_cpu (.core_clk(core_clk), .want_code(want_code), .bounce(bounce), .want_en(want_en),
        .voltage_select_code(code), .enable(enable));
    vds_stepper u_dut (.core_clk(core_clk), .rst(rst), .enable(enable), .voltage_select_code(code),
        .reference_level_q(level), .reference_uv_q(uv), .status_q(st));

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function logic [20:0] uv_of(input logic [7:0] c);
        return 21'(556250 - (int'(c) - 169) * 6250);
    endfunction

    task end_sim;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    // Qualify 10..15 cycles, then first step lands on a free-running tick
    task move_to(input logic [7:0] c);
        int t, d;
        d = (c > level) ? c - level : level - c;
        want_code = c;
        t = 0;
        while (level !== c && t < 4000)
        begin
            cyc(1);
            t++;
        end
        chk(level, c);
        chk(t > (d - 1) * 14 + 5 && t < d * 14 + 20, 1);
        cyc(2);
        chk(uv, uv_of(c));
        chk(st.stepping, 0);
        $display("test move to %0h done", c);
    endtask

    // Every code change is one step, steps 14 cycles apart within a run
    always @(posedge core_clk)
    begin
        if (!rst && level !== lvl_prev)
        begin
            chk((level > lvl_prev) ? level - lvl_prev : lvl_prev - level, 1);
            if (svalid)
                chk(scnt, 14);
            scnt = 1;
            svalid = 1;
        end
        else
            scnt++;
        if (rst || !st.stepping)
            svalid = 0;
        lvl_prev = level;
    end

    initial
    begin
        repeat (80000) @(posedge core_clk);
        miscompares++;
        end_sim;
    end

    initial
    begin
        logic [7:0] c;
        rst = 1'b1;
        want_en = 1'b0;
        bounce = 1'b0;
        want_code = 8'h00;
        repeat (10) @(posedge core_clk);
        #2 rst = 1'b0;
        cyc(2);
        chk(uv, uv_of(8'h00));
        want_en = 1'b1;
        cyc(3);
        chk(st.regulating, 1);
        move_to(8'hA9);
        move_to(8'hFD);
        for (int i = 0; i < 8; i++)
        begin
            c = 8'(xs() % 254);
            if (c == level)
                c = c ^ 8'h01;
            move_to(c);
        end
        move_to(8'h40);
        want_code = 8'h50;
        cyc(8);
        want_code = 8'h40;
        cyc(60);
        chk(level, 8'h40);
        bounce = 1'b1;
        want_code = 8'h60;
        cyc(80);
        chk(level, 8'h40);
        bounce = 1'b0;
        want_code = 8'h40;
        cyc(20);
        $display("test qualify done");
        for (int i = 0; i < 2; i++)
        begin
            want_code = 8'hFE | 8'(i);
            cyc(13);
            want_code = 8'h40;
            cyc(20);
            chk(st.off_latched, 0);
            want_code = 8'hFE | 8'(i);
            cyc(30);
            chk(st, 32'h1);
            want_code = 8'h30;
            cyc(60);
            chk(level, 8'h40);
            // Retarget to the frozen level, so the later move is timed from rest
            want_code = 8'h40;
            cyc(20);
            chk(st, 32'h1);
            want_en = 1'b0;
            cyc(3);
            chk(st, 32'h0);
            want_en = 1'b1;
            cyc(3);
            chk(st.regulating, 1);
            move_to(8'h30);
            move_to(8'h40);
            $display("test off code %0d done", i);
        end
        end_sim;
    end
endmodule

`default_nettype wire
